// file: src/tap_pkg.sv
// Purpose: constants shared by the scan port block
// Assumes: three-bit instruction register, 89-cell boundary chain
// Notes:   identity fields hold arbitrary neutral values
package tap_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int IR_WIDTH = 3;
    localparam int ID_WIDTH = 32;
    localparam int BSR_LEN = 89;

    // ----------------------------------------------------------------
    // instruction codes
    // ----------------------------------------------------------------
    localparam logic [2:0] INS_EXT_TEST = 3'h0;
    localparam logic [2:0] INS_IDENT = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    // capture pattern for the instruction register
    localparam logic [2:0] IR_CAPTURE = 3'h1;

    // ----------------------------------------------------------------
    // identification fields
    // ----------------------------------------------------------------
    localparam int REV_MSB = 31;
    localparam int REV_LSB = 29;
    localparam int DEV_MSB = 28;
    localparam int DEV_LSB = 12;
    localparam int MFR_MSB = 11;
    localparam int MFR_LSB = 1;
    localparam int PRESENT_BIT = 0;
    // arbitrary value
    localparam logic [2:0] REV_DEFAULT = 3'h0;
    // arbitrary value
    localparam logic [16:0] DEV_DEFAULT = 17'h00a5a;
    // arbitrary value
    localparam logic [10:0] MFR_DEFAULT = 11'h05a;

    // ----------------------------------------------------------------
    // boundary chain layout (index 0 is chain bit 1)
    // ----------------------------------------------------------------
    localparam int CTRL_CELL = 88;
    localparam logic CTRL_PRESET = 1'b1;
    // set bits mark cells tied to unconnected package positions
    localparam logic [88:0] NC_MASK = 89'h0;

    typedef enum logic [3:0]
    {
        ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
        ST_PAU_DR, ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } tap_state_t;

endpackage

// file: src/tap_step_if.sv
// Purpose: carries the test clock edge events between modules
// Assumes: all signals on SYS_CLK
// Notes:   rise and fall are one-cycle pulses; tms and tdi are levels
`timescale 1ns/1ps
interface tap_step_if;
    logic rise;
    logic fall;
    logic tms;
    logic tdi;
    modport src (output rise, output fall, output tms, output tdi);
    modport dst (input rise, input fall, input tms, input tdi);
endinterface

// file: src/tap_edge_sync.sv
// Purpose: synchronise the test pins and find test clock edges
// Assumes: test clock far slower than SYS_CLK
// Notes:   tms and tdi are sampled from the second stage
`timescale 1ns/1ps
module tap_edge_sync
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    tap_step_if.src step
);

    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic tck_old_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
            tck_old_q <= 1'b0;
        end
        else
        begin
            meta_q <= {tck_in, tms_in, tdi_in};
            sync_q <= meta_q;
            tck_old_q <= sync_q[2];
        end
    end

    assign step.rise = sync_q[2] & ~tck_old_q;
    assign step.fall = ~sync_q[2] & tck_old_q;
    assign step.tms = sync_q[1];
    assign step.tdi = sync_q[0];

endmodule

// file: src/tap_ctrl_fsm.sv
// Purpose: sixteen-state test port controller
// Assumes: advanced on each synchronised test clock rise
// Notes:   state reported to the top as a plain value
`timescale 1ns/1ps
module tap_ctrl_fsm
(
    input wire logic clk,
    input wire logic rst_n,
    tap_step_if.dst step,
    output tap_pkg::tap_state_t state
);

    tap_pkg::tap_state_t st_q;
    tap_pkg::tap_state_t st_d;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            tap_pkg::ST_RESET:
                st_d = step.tms ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
            tap_pkg::ST_IDLE:
                st_d = step.tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_DR:
                st_d = step.tms ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
            tap_pkg::ST_CAP_DR, tap_pkg::ST_SH_DR:
                st_d = step.tms ? tap_pkg::ST_EX1_DR : tap_pkg::ST_SH_DR;
            tap_pkg::ST_EX1_DR:
                st_d = step.tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAU_DR;
            tap_pkg::ST_PAU_DR:
                st_d = step.tms ? tap_pkg::ST_EX2_DR : tap_pkg::ST_PAU_DR;
            tap_pkg::ST_EX2_DR:
                st_d = step.tms ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SH_DR;
            tap_pkg::ST_UPD_DR, tap_pkg::ST_UPD_IR:
                st_d = step.tms ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_IR:
                st_d = step.tms ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
            tap_pkg::ST_CAP_IR, tap_pkg::ST_SH_IR:
                st_d = step.tms ? tap_pkg::ST_EX1_IR : tap_pkg::ST_SH_IR;
            tap_pkg::ST_EX1_IR:
                st_d = step.tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAU_IR;
            tap_pkg::ST_PAU_IR:
                st_d = step.tms ? tap_pkg::ST_EX2_IR : tap_pkg::ST_PAU_IR;
            tap_pkg::ST_EX2_IR:
                st_d = step.tms ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SH_IR;
            default:
                st_d = tap_pkg::ST_RESET;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= tap_pkg::ST_RESET;
        else if (step.rise)
            st_q <= st_d;
    end

    assign state = st_q;

endmodule

// file: src/sram_scan_tap.sv
// Purpose: boundary scan test port of a pipelined synchronous SRAM
// Assumes: SYS_CLK at least four times the test clock rate
// Notes:   scan data shifts in at the top cell and leaves at cell 0
//
// Behaviour
// - boundary chain holds 89 cells, the last an internal control cell
// - code 000 external test: chain selected, ring captured, outputs set by control cell
// - code 001 identification: 32-bit value loaded and shifted
// - code 010 sample with high impedance: chain selected, outputs off
// - code 100 sample/preload: ring captured, chain selected, SRAM untouched
// - code 111 bypass: one-bit register on serial path
// - identification bits 31:29 hold the revision
// - identification bits 28:12 hold the fixed device code
// - identification bits 11:1 hold the manufacturer code
// - identification bit 0 always reads 1
// - cells of unconnected positions hold fixed low
// - control cell 89 presets high until updated otherwise
// - instruction register is three bits wide
// - identification is the instruction after power-up and test reset
// - during external test the control cell enables or blocks outputs
`timescale 1ns/1ps
module sram_scan_tap
#(
    parameter logic [2:0] REVISION = tap_pkg::REV_DEFAULT,
    parameter logic [16:0] DEVICE_CODE = tap_pkg::DEV_DEFAULT,
    parameter logic [10:0] MAKER_CODE = tap_pkg::MFR_DEFAULT
)
(
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic TEST_CLK,
    input wire logic TEST_MODE,
    input wire logic TEST_DIN,
    input wire logic [tap_pkg::BSR_LEN-1:0] RING_IN,
    output logic TEST_DOUT,
    output logic TEST_DOUT_OE,
    output logic [tap_pkg::BSR_LEN-1:0] RING_OUT,
    output logic RING_TEST_MODE,
    output logic SRAM_OUT_EN
);

    // ----------------------------------------------------------------
    // pin synchroniser and controller
    // ----------------------------------------------------------------
    tap_step_if step ();
    tap_pkg::tap_state_t state;

    tap_edge_sync u_sync
    (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .tck_in(TEST_CLK),
        .tms_in(TEST_MODE),
        .tdi_in(TEST_DIN),
        .step(step)
    );

    tap_ctrl_fsm u_fsm
    (
        .clk(SYS_CLK),
        .rst_n(NRST),
        .step(step),
        .state(state)
    );

    // ----------------------------------------------------------------
    // instruction register
    // ----------------------------------------------------------------
    logic [tap_pkg::IR_WIDTH-1:0] ir_sh_q;
    logic [tap_pkg::IR_WIDTH-1:0] ir_q;

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            ir_sh_q <= tap_pkg::IR_CAPTURE;
        else if (step.rise)
        begin
            if (state == tap_pkg::ST_CAP_IR)
                ir_sh_q <= tap_pkg::IR_CAPTURE;
            else if (state == tap_pkg::ST_SH_IR)
                ir_sh_q <= {step.tdi, ir_sh_q[tap_pkg::IR_WIDTH-1:1]};
        end
    end

    // reserved codes are not trapped; they simply act as bypass
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            ir_q <= tap_pkg::INS_IDENT;
        else if (step.fall)
        begin
            if (state == tap_pkg::ST_RESET)
                ir_q <= tap_pkg::INS_IDENT;
            else if (state == tap_pkg::ST_UPD_IR)
                ir_q <= ir_sh_q;
        end
    end

    logic sel_bsr;
    logic sel_id;
    logic outs_off;
    always_comb
    begin
        sel_bsr = 1'b0;
        sel_id = 1'b0;
        outs_off = 1'b0;
        case (ir_q)
            tap_pkg::INS_EXT_TEST:
                sel_bsr = 1'b1;
            tap_pkg::INS_IDENT:
                sel_id = 1'b1;
            tap_pkg::INS_SAMPLE_Z:
            begin
                sel_bsr = 1'b1;
                outs_off = 1'b1;
            end
            tap_pkg::INS_SAMPLE:
                sel_bsr = 1'b1;
            default:
                sel_bsr = 1'b0; // bypass and reserved codes
        endcase
    end

    // ----------------------------------------------------------------
    // identification register
    // ----------------------------------------------------------------
    logic [tap_pkg::ID_WIDTH-1:0] id_value;
    always_comb
    begin
        id_value = '0;
        id_value[tap_pkg::REV_MSB:tap_pkg::REV_LSB] = REVISION;
        id_value[tap_pkg::DEV_MSB:tap_pkg::DEV_LSB] = DEVICE_CODE;
        id_value[tap_pkg::MFR_MSB:tap_pkg::MFR_LSB] = MAKER_CODE;
        id_value[tap_pkg::PRESENT_BIT] = 1'b1;
    end

    logic [tap_pkg::ID_WIDTH-1:0] id_sh_q;
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            id_sh_q <= '0;
        else if (step.rise && sel_id)
        begin
            if (state == tap_pkg::ST_CAP_DR)
                id_sh_q <= id_value;
            else if (state == tap_pkg::ST_SH_DR)
                id_sh_q <= {step.tdi, id_sh_q[tap_pkg::ID_WIDTH-1:1]};
        end
    end

    // ----------------------------------------------------------------
    // bypass register
    // ----------------------------------------------------------------
    logic byp_q;
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            byp_q <= 1'b0;
        else if (step.rise)
        begin
            if (state == tap_pkg::ST_CAP_DR)
                byp_q <= 1'b0;
            else if (state == tap_pkg::ST_SH_DR)
                byp_q <= step.tdi;
        end
    end

    // ----------------------------------------------------------------
    // ring synchroniser
    // ----------------------------------------------------------------
    // the ring moves on the SRAM clock; a capture may meet a bit in
    // flight, and the two stages keep that from going metastable
    logic [tap_pkg::BSR_LEN-1:0] ring_meta_q;
    logic [tap_pkg::BSR_LEN-1:0] ring_sync_q;

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ring_meta_q <= '0;
            ring_sync_q <= '0;
        end
        else
        begin
            ring_meta_q <= RING_IN;
            ring_sync_q <= ring_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // boundary chain: shift stage and update latch
    // ----------------------------------------------------------------
    logic [tap_pkg::BSR_LEN-1:0] bsr_sh_q;
    logic [tap_pkg::BSR_LEN-1:0] bsr_up_q;
    logic [tap_pkg::BSR_LEN-1:0] preset_v;
    logic [tap_pkg::BSR_LEN-1:0] cap_v;

    // reset pattern: control cell high, every other cell low
    localparam logic [tap_pkg::BSR_LEN-1:0] CELL_PRESET =
        {{(tap_pkg::BSR_LEN-1){1'b0}}, tap_pkg::CTRL_PRESET}
        << tap_pkg::CTRL_CELL;

    always_comb
    begin
        preset_v = '0;
        preset_v[tap_pkg::CTRL_CELL] = tap_pkg::CTRL_PRESET;
        // the control cell has no ball; it captures its own latched value
        cap_v = ring_sync_q & ~tap_pkg::NC_MASK;
        cap_v[tap_pkg::CTRL_CELL] = bsr_up_q[tap_pkg::CTRL_CELL];
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            bsr_sh_q <= '0;
        else if (step.rise && sel_bsr)
        begin
            if (state == tap_pkg::ST_CAP_DR)
                bsr_sh_q <= cap_v;
            else if (state == tap_pkg::ST_SH_DR)
                bsr_sh_q <= {step.tdi,
                    bsr_sh_q[tap_pkg::BSR_LEN-1:1]};
        end
    end

    // update on the falling edge, as the standard asks for update states
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            bsr_up_q <= CELL_PRESET;
        else if (step.fall)
        begin
            if (state == tap_pkg::ST_RESET)
                bsr_up_q <= preset_v;
            else if (state == tap_pkg::ST_UPD_DR && sel_bsr)
                bsr_up_q <= bsr_sh_q & ~tap_pkg::NC_MASK;
        end
    end

    // ----------------------------------------------------------------
    // serial output, changes on the falling test clock edge
    // ----------------------------------------------------------------
    logic dout_d;
    logic shifting;
    always_comb
    begin
        shifting = (state == tap_pkg::ST_SH_DR)
            || (state == tap_pkg::ST_SH_IR);
        if (state == tap_pkg::ST_SH_IR)
            dout_d = ir_sh_q[0];
        else if (sel_bsr)
            dout_d = bsr_sh_q[0];
        else if (sel_id)
            dout_d = id_sh_q[0];
        else
            dout_d = byp_q;
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            TEST_DOUT <= 1'b0;
        else if (step.fall)
            TEST_DOUT <= dout_d;
    end

    // enabled only in the shift states, so that several parts may share
    // one serial return line
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            TEST_DOUT_OE <= 1'b0;
        else if (step.fall)
            TEST_DOUT_OE <= shifting;
    end

    // ----------------------------------------------------------------
    // SRAM side controls
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            RING_OUT <= '0;
        else
            RING_OUT <= bsr_up_q;
    end

    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            RING_TEST_MODE <= 1'b0;
        else
            RING_TEST_MODE <= (ir_q == tap_pkg::INS_EXT_TEST);
    end

    // outside external test the cell is ignored, so a preload cannot
    // disturb normal SRAM reads
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
            SRAM_OUT_EN <= 1'b1;
        else if (ir_q == tap_pkg::INS_EXT_TEST)
            SRAM_OUT_EN <= bsr_up_q[tap_pkg::CTRL_CELL];
        else
            SRAM_OUT_EN <= ~outs_off;
    end

endmodule

// file: tb/sram_scan_tap_monitor.sv
// Purpose: port-level timing checks for the scan test port
// Assumes: test clock phases last at least four SYS_CLK cycles
// Notes:   pin changes must follow the synchronised test clock edges
`timescale 1ns/1ps
module sram_scan_tap_monitor
(
    input wire logic SYS_CLK,
    input wire logic NRST,
    input wire logic TEST_CLK,
    input wire logic TEST_DOUT,
    input wire logic TEST_DOUT_OE,
    input wire logic [88:0] RING_OUT,
    input wire logic RING_TEST_MODE,
    input wire logic SRAM_OUT_EN
);
    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);

    // update latches move only after a test clock fall
    chk_ring_after_fall: assert property (
        $changed(RING_OUT) |-> !$past(TEST_CLK, 2))
        else $error("ring outputs changed outside the low phase");
    chk_dout_after_fall: assert property (
        $changed(TEST_DOUT) |-> !$past(TEST_CLK, 2))
        else $error("serial out changed outside the low phase");
    chk_mode_after_fall: assert property (
        $changed(RING_TEST_MODE) |-> !$past(TEST_CLK, 2))
        else $error("test mode changed outside the low phase");
    chk_sram_en_fall: assert property (
        $changed(SRAM_OUT_EN) |-> !$past(TEST_CLK, 2))
        else $error("output enable changed outside the low phase");
    // the serial enable is registered on the fall, like the data
    chk_oe_after_fall: assert property (
        $changed(TEST_DOUT_OE) |-> !$past(TEST_CLK, 2))
        else $error("serial enable changed outside the low phase");
    chk_oe_full_clock: assert property (
        $rose(TEST_DOUT_OE) |-> TEST_DOUT_OE [*8])
        else $error("shift window shorter than one test clock");
    chk_ext_out_ctrl: assert property (
        RING_TEST_MODE && $stable(RING_TEST_MODE) && $stable(RING_OUT[88])
        |-> SRAM_OUT_EN == RING_OUT[88])
        else $error("output enable does not follow the control cell");
    chk_mode_on_hold: assert property (
        $rose(RING_TEST_MODE) |-> RING_TEST_MODE [*8])
        else $error("test mode dropped within one test clock");
endmodule

bind sram_scan_tap sram_scan_tap_monitor sram_scan_tap_monitor_i
(
    .SYS_CLK(SYS_CLK),
    .NRST(NRST),
    .TEST_CLK(TEST_CLK),
    .TEST_DOUT(TEST_DOUT),
    .TEST_DOUT_OE(TEST_DOUT_OE),
    .RING_OUT(RING_OUT),
    .RING_TEST_MODE(RING_TEST_MODE),
    .SRAM_OUT_EN(SRAM_OUT_EN)
);

// file: tb/scan_master.sv
// Purpose: behavioural boundary-scan test controller
// Assumes: test clock of 800 ns, standing low between frames
// Notes:   pins move at the start of the low phase, serial out read late in high phase
`timescale 1ns/1ps
module scan_master
(
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    logic tdo_seen;

    // a released serial line floats to its pull-up level
    assign tdo_seen = tdo_oe ? tdo : 1'b1;

    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // ----------------------------------------------------------------
    // one test clock
    // ----------------------------------------------------------------
    task automatic step(input logic m, input logic d, output logic q);
    begin
        tms = m;
        tdi = d;
        #400 tck = 1'b1;
        #350 q = tdo_seen;
        #50 tck = 1'b0;
    end
    endtask

    task automatic tap_reset;
        logic q;
    begin
        repeat (5) step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    end
    endtask

    // from idle: scan n bits lsb first, update, back to idle
    task automatic scan(input logic ir, input int n,
        input logic [127:0] din, output logic [127:0] dout);
        logic q;
    begin
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir)
            step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int k = 0; k < n; k++)
        begin
            step(k == n - 1, din[k], q);
            dout[k] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    end
    endtask
endmodule

// file: tb/testbench.sv
// Purpose: self-checking bench of the scan test port
// Assumes: reserved instruction codes are never loaded
// Notes:   bench code runs 37 ns off the SYS_CLK grid
`timescale 1ns/1ps
module testbench;
    logic SYS_CLK = 1'b0;
    logic NRST = 1'b0;
    logic TEST_CLK, TEST_MODE, TEST_DIN, TEST_DOUT, TEST_DOUT_OE;
    logic RING_TEST_MODE, SRAM_OUT_EN;
    logic [88:0] RING_IN = '0;
    logic [88:0] RING_OUT;
    logic [88:0] pat;
    logic [127:0] q;
    logic [31:0] id_exp;
    int num_errors = 0;
    int checks = 0;

    assign id_exp = {tap_pkg::REV_DEFAULT, tap_pkg::DEV_DEFAULT,
        tap_pkg::MFR_DEFAULT, 1'b1};
    always #50 SYS_CLK = ~SYS_CLK;

    sram_scan_tap sram_scan_tap_i (.SYS_CLK(SYS_CLK), .NRST(NRST),
        .TEST_CLK(TEST_CLK), .TEST_MODE(TEST_MODE), .TEST_DIN(TEST_DIN),
        .RING_IN(RING_IN), .TEST_DOUT(TEST_DOUT),
        .TEST_DOUT_OE(TEST_DOUT_OE), .RING_OUT(RING_OUT),
        .RING_TEST_MODE(RING_TEST_MODE), .SRAM_OUT_EN(SRAM_OUT_EN));
    scan_master scan_master_i (.tck(TEST_CLK), .tms(TEST_MODE),
        .tdi(TEST_DIN), .tdo(TEST_DOUT), .tdo_oe(TEST_DOUT_OE));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check_eq(input logic [127:0] got, input logic [127:0] want);
    begin
        checks++;
        if (got !== want)
        begin
            num_errors++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    end
    endtask

    task automatic stop_test;
    begin
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
    endtask

    task automatic set_ring(input logic [88:0] v);
    begin
        @(posedge SYS_CLK);
        RING_IN <= v;
        #37;
    end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_power_id;
    begin
        check_eq(RING_OUT[88], 1'b1);
        check_eq({RING_TEST_MODE, SRAM_OUT_EN}, 2'b01);
        scan_master_i.tap_reset();
        scan_master_i.scan(1'b0, 32, '0, q);
        check_eq(q[31:0], id_exp);
        check_eq(q[0], 1'b1);
        $display("test power_id done");
    end
    endtask

    task automatic t_bypass;
    begin
        scan_master_i.scan(1'b1, 3, tap_pkg::INS_BYPASS, q);
        check_eq(q[2:0], tap_pkg::IR_CAPTURE);
        scan_master_i.scan(1'b0, 2, 128'h3, q);
        check_eq(q[1:0], 2'b10);
        check_eq(SRAM_OUT_EN, 1'b1);
        $display("test bypass done");
    end
    endtask

    task automatic t_sample;
    begin
        set_ring({1'b0, {11{8'h3c}}});
        pat = {1'b0, {11{8'h96}}};
        scan_master_i.scan(1'b1, 3, tap_pkg::INS_SAMPLE, q);
        scan_master_i.scan(1'b0, 90, {pat, 1'b1}, q);
        check_eq(q[88:0], {1'b1, RING_IN[87:0] &
            ~tap_pkg::NC_MASK[87:0]});
        check_eq(q[89], 1'b1);
        check_eq(RING_OUT, pat);
        check_eq({RING_TEST_MODE, SRAM_OUT_EN}, 2'b01);
        $display("test sample done");
    end
    endtask

    task automatic t_extest;
    begin
        set_ring({1'b1, {11{8'h5a}}});
        scan_master_i.scan(1'b1, 3, tap_pkg::INS_EXT_TEST, q);
        check_eq({RING_TEST_MODE, SRAM_OUT_EN}, 2'b10);
        scan_master_i.scan(1'b0, 89, {1'b1, 88'h0}, q);
        check_eq(q[88:0], {1'b0, RING_IN[87:0]});
        check_eq(RING_OUT, {1'b1, 88'h0});
        check_eq(SRAM_OUT_EN, 1'b1);
        $display("test extest done");
    end
    endtask

    task automatic t_sample_z;
    begin
        set_ring({1'b0, {11{8'hc3}}});
        scan_master_i.scan(1'b1, 3, tap_pkg::INS_SAMPLE_Z, q);
        check_eq({RING_TEST_MODE, SRAM_OUT_EN}, 2'b00);
        scan_master_i.scan(1'b0, 89, {1'b0, 88'h1}, q);
        check_eq(q[88:0], {1'b1, RING_IN[87:0]});
        check_eq(SRAM_OUT_EN, 1'b0);
        $display("test sample_z done");
    end
    endtask

    task automatic t_test_reset;
    begin
        scan_master_i.tap_reset();
        check_eq(RING_OUT[88], 1'b1);
        check_eq({RING_TEST_MODE, SRAM_OUT_EN}, 2'b01);
        scan_master_i.scan(1'b0, 32, '0, q);
        check_eq(q[31:0], id_exp);
        $display("test test_reset done");
    end
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge SYS_CLK);
        NRST <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        #37;
        t_power_id();
        t_bypass();
        t_sample();
        t_extest();
        t_sample_z();
        t_test_reset();
        stop_test();
    end

    // runs are near 330 us; a hung handshake ends the run here
    initial
    begin
        #1_000_000;
        num_errors++;
        stop_test();
    end
endmodule
